// >>> core/osc_ctrl.sv
// Observation scan controller: AXI4-Lite registers, pattern sequencer,
// per-cycle enable gating, a dedicated cell chain and a signature register.
// Assumes observed nodes and chain input come from logic on aclk.
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.svh"
module osc_ctrl
    import osc_pkg::*;
#(
    parameter int               NCELL       = 8,
    parameter int               CW          = 16,
    parameter logic [NCELL-1:0] SHADOW_MASK = '0
)
(
    // Clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite write address
    input  wire logic [`OSC_AW-1:0] s_axi_awaddr,
    input  wire logic [2:0]         s_axi_awprot,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [`OSC_AW-1:0] s_axi_araddr,
    input  wire logic [2:0]         s_axi_arprot,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Observed design nodes and chain input
    input  wire logic [NCELL-1:0]   obs_node,
    input  wire logic               obs_chain_si,
    // Test controls and results
    output logic                    scan_shift_enable,
    output logic                    percycle_static_en,
    output logic                    percycle_dyn_en,
    output logic                    sig_accum_en,
    output logic                    obs_chain_so,
    output logic [NCELL-1:0]        obs_q
);
    osc_ctrl_type    ctrl_q;
    logic [CW-1:0]   warm_q;
    logic [CW-1:0]   begin_q;
    logic [CW-1:0]   pats_q;
    logic [CW-1:0]   shlen_q;
    logic            start_q;
    logic            done_q;
    logic [31:0]     sig_q;

    logic [`OSC_AW-1:0] awaddr_q;
    logic [31:0]     wdata_q;
    logic [3:0]      wstrb_q;
    logic            awready_q;
    logic            wready_q;
    logic            bvalid_q;
    logic [1:0]      bresp_q;
    logic            arready_q;
    logic            rvalid_q;
    logic [31:0]     rdata_q;
    logic [1:0]      rresp_q;
    logic            wr_go;
    logic            wr_hit;

    osc_state_type   state_q;
    osc_state_type   state_d;
    logic [CW:0]     pat_q;
    logic [CW:0]     pat_d;
    logic [CW-1:0]   sh_q;
    logic [CW-1:0]   sh_d;
    logic [CW:0]     total;
    logic [CW:0]     reg_start;
    logic [CW:0]     sig_start;
    logic [CW-1:0]   sh_last;
    logic            flush_n;
    logic            run_d;
    logic            shifting_d;
    logic            is_flush_d;
    logic            fsm_ok_d;
    logic            static_d;
    logic            se_q;
    logic            static_q;
    logic            dyn_q;
    logic            misr_q;
    logic [NCELL-1:0] cell_q;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // Write channel: address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            awaddr_q  <= '0;
        end else if (s_axi_awvalid && awready_q) begin
            awready_q <= 1'b0;
            awaddr_q  <= s_axi_awaddr;
        end else if (bvalid_q && s_axi_bready) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b1;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (s_axi_wvalid && wready_q) begin
            wready_q <= 1'b0;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (bvalid_q && s_axi_bready) begin
            wready_q <= 1'b1;
        end
    end

    assign wr_go  = !awready_q && !wready_q && !bvalid_q;
    assign wr_hit = (awaddr_q[1:0] == 2'b00)
                 && (awaddr_q <= `OSC_OFF_PATIDX);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `OSC_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? `OSC_RESP_OKAY : `OSC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Register writes; read-only offsets accept and ignore data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q  <= '0;
            warm_q  <= `OSC_RST_WARMUP;
            begin_q <= `OSC_RST_BEGIN;
            pats_q  <= `OSC_RST_PATS;
            shlen_q <= `OSC_RST_SHLEN;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (wr_go) begin
                unique case (awaddr_q)
                    `OSC_OFF_CTRL: begin
                        if (wstrb_q[0]) begin
                            ctrl_q.static_en <=
                                wdata_q[`OSC_CTRL_STATIC];
                            ctrl_q.observe_point_enable <=
                                wdata_q[`OSC_CTRL_OPE];
                            ctrl_q.sig_delay <=
                                wdata_q[`OSC_CTRL_DELAY];
                            start_q <= wdata_q[`OSC_CTRL_START]
                                    && state_q == OSC_IDLE;
                        end
                    end
                    `OSC_OFF_WARMUP: warm_q <= CW'(merge(32'(warm_q),
                                               wdata_q, wstrb_q));
                    `OSC_OFF_BEGIN: begin_q <= CW'(merge(32'(begin_q),
                                               wdata_q, wstrb_q));
                    `OSC_OFF_PATS: pats_q <= CW'(merge(32'(pats_q),
                                             wdata_q, wstrb_q));
                    `OSC_OFF_SHLEN: shlen_q <= CW'(merge(32'(shlen_q),
                                               wdata_q, wstrb_q));
                    default: ;
                endcase
            end
        end
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= `OSC_RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= `OSC_RESP_OKAY;
            rdata_q   <= '0;
            unique case (s_axi_araddr)
                `OSC_OFF_CTRL:   rdata_q <= {29'h0, ctrl_q};
                `OSC_OFF_WARMUP: rdata_q <= 32'(warm_q);
                `OSC_OFF_BEGIN:  rdata_q <= 32'(begin_q);
                `OSC_OFF_PATS:   rdata_q <= 32'(pats_q);
                `OSC_OFF_SHLEN:  rdata_q <= 32'(shlen_q);
                `OSC_OFF_STATUS: rdata_q <= {28'h0, se_q, dyn_q,
                                             done_q,
                                             state_q != OSC_IDLE};
                `OSC_OFF_SIG:    rdata_q <= sig_q;
                `OSC_OFF_PATIDX: rdata_q <= 32'(pat_q);
                default:         rresp_q <= `OSC_RESP_SLVERR;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    // Pattern order: warm-ups, optional flush, then regular patterns
    assign flush_n   = (begin_q != '0); // R8
    assign reg_start = {1'b0, warm_q} + {{CW{1'b0}}, flush_n};
    assign total     = reg_start + {1'b0, pats_q};
    assign sig_start = {1'b0, warm_q} + (CW+1)'(1)
                     + {{CW{1'b0}}, ctrl_q.sig_delay}; // R9
    // A zero length still shifts once, so the chain always moves
    assign sh_last   = (shlen_q == '0) ? '0 : shlen_q - CW'(1);

    always_comb begin
        state_d = state_q;
        pat_d   = pat_q;
        sh_d    = sh_q;
        unique case (state_q)
            OSC_IDLE: begin
                if (start_q) begin
                    pat_d   = '0;
                    sh_d    = '0;
                    state_d = (total == '0) ? OSC_IDLE : OSC_SHIFT;
                end
            end
            OSC_SHIFT: begin
                sh_d = sh_q + CW'(1);
                if (sh_q == sh_last) begin
                    sh_d    = '0;
                    state_d = OSC_CAPT;
                end
            end
            OSC_CAPT: begin
                pat_d   = pat_q + (CW+1)'(1);
                state_d = (pat_d == total) ? OSC_UNLD : OSC_SHIFT;
            end
            OSC_UNLD: begin
                sh_d = sh_q + CW'(1);
                if (sh_q == sh_last) begin
                    sh_d    = '0;
                    state_d = OSC_IDLE;
                end
            end
            default: state_d = OSC_IDLE;
        endcase
    end

    assign run_d      = (state_d != OSC_IDLE);
    assign shifting_d = (state_d == OSC_SHIFT) || (state_d == OSC_UNLD);
    assign is_flush_d = run_d && pat_d >= {1'b0, warm_q}
                     && pat_d < reg_start;
    // Sequencer term: off in warm-ups, flush, and first shift-in
    assign fsm_ok_d   = run_d && pat_d >= reg_start
                     && !(pat_d == reg_start && shifting_d); // R4
    assign static_d   = ctrl_q.static_en && !is_flush_d; // R8

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= OSC_IDLE;
            pat_q   <= '0;
            sh_q    <= '0;
        end else begin
            state_q <= state_d;
            pat_q   <= pat_d;
            sh_q    <= sh_d;
        end
    end

    // Controls leave from flops aligned with the next state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            se_q     <= 1'b0;
            static_q <= 1'b0;
            dyn_q    <= 1'b0;
            misr_q   <= 1'b0;
        end else begin
            se_q     <= shifting_d;
            static_q <= static_d;
            dyn_q    <= static_d && fsm_ok_d; // R3
            misr_q   <= shifting_d && pat_d >= sig_start; // R9
        end
    end

    // Done is sticky; its setting wins over the clear by a new start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q <= 1'b0;
        end else if (state_q == OSC_UNLD && state_d == OSC_IDLE) begin
            done_q <= 1'b1;
        end else if (start_q) begin
            done_q <= 1'b0;
        end
    end

    // Signature compaction of the chain output while enabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sig_q <= `OSC_RST_SIG;
        end else if (start_q) begin
            sig_q <= `OSC_RST_SIG;
        end else if (misr_q) begin
            sig_q <= {sig_q[30:0], ^(sig_q & `OSC_SIG_TAPS)}
                   ^ {31'h0, cell_q[NCELL-1]};
        end
    end

    // Dedicated chain of observation cells only
    for (genvar i = 0; i < NCELL; i++) begin : g_cell
        osc_cell u_cell (
            .aclk                 (aclk),
            .aresetn              (aresetn),
            .scan_shift_enable    (se_q),
            .dyn_en               (dyn_q && !SHADOW_MASK[i]), // R11
            .observe_point_enable (ctrl_q.observe_point_enable), // R7
            .d                    (obs_node[i]),
            .si                   ((i == 0) ? obs_chain_si
                                            : cell_q[(i == 0) ? 0 : i-1]),
            .q                    (cell_q[i])
        ); // R10
    end

    // Per-cycle on folds every cycle, off only at capture
    assign percycle_dyn_en    = dyn_q; // R1 R2
    assign percycle_static_en = static_q;
    assign scan_shift_enable  = se_q;
    assign sig_accum_en       = misr_q;
    assign obs_chain_so       = cell_q[NCELL-1];
    assign obs_q              = cell_q;

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
endmodule : osc_ctrl
`default_nettype wire

// >>> core/osc_consts.svh
// Constants for the observation scan cell controller: register offsets,
// field positions, reset values and signature taps.
// Assumes inclusion by bare name from the controller module and the bench.
// Operation
// R1 - Per-cycle on: cells observe every shift and capture
// R2 - Per-cycle off: cells observe only at capture
// R3 - Dynamic enable is static enable AND sequencer
// R4 - Dynamic low in warm-up and first shift-in
// R5 - Shift: load si, or d xor si
// R6 - No shift: load d, or d xor q
// R7 - Observe enable gates observation independently
// R8 - Begin above zero adds one flush pattern
// R9 - Delay control postpones signature start one pattern
// R10 - Cells form their own dedicated chain
// R11 - Shadow-cone cells capture only at capture
// R12 - Observe enable low: plain scan cell
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH

`define OSC_AW          8
`define OSC_OFF_CTRL    8'h00
`define OSC_OFF_WARMUP  8'h04
`define OSC_OFF_BEGIN   8'h08
`define OSC_OFF_PATS    8'h0c
`define OSC_OFF_SHLEN   8'h10
`define OSC_OFF_STATUS  8'h14
`define OSC_OFF_SIG     8'h18
`define OSC_OFF_PATIDX  8'h1c

`define OSC_CTRL_STATIC 0
`define OSC_CTRL_OPE    1
`define OSC_CTRL_DELAY  2
`define OSC_CTRL_START  3

`define OSC_ST_BUSY     0
`define OSC_ST_DONE     1
`define OSC_ST_DYN      2
`define OSC_ST_SHIFT    3

`define OSC_RST_WARMUP  16'h0000
`define OSC_RST_BEGIN   16'h0000
`define OSC_RST_PATS    16'h0001
`define OSC_RST_SHLEN   16'h0008
`define OSC_RST_SIG     32'h0000_0000

`define OSC_RESP_OKAY   2'b00
`define OSC_RESP_SLVERR 2'b10

`define OSC_SIG_TAPS    32'h8020_0003

`endif

// >>> core/osc_pkg.sv
// Types shared by the observation scan controller and its cells.
// Assumes osc_consts.svh is on the include path.
`default_nettype none
package osc_pkg;
    typedef enum logic [3:0] {
        OSC_IDLE  = 4'b0001,
        OSC_SHIFT = 4'b0010,
        OSC_CAPT  = 4'b0100,
        OSC_UNLD  = 4'b1000
    } osc_state_type;

    typedef struct packed {
        logic sig_delay;
        logic observe_point_enable;
        logic static_en;
    } osc_ctrl_type;
endpackage : osc_pkg
`default_nettype wire

// >>> core/osc_cell.sv
// One observation scan cell: a scan flop that can fold its observed node
// into its state. Assumes controls come from flops on the same clock.
`timescale 1ns/1ps
`default_nettype none
module osc_cell
    import osc_pkg::*;
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Controls
    input  wire logic scan_shift_enable,
    input  wire logic dyn_en,
    input  wire logic observe_point_enable,
    // Data
    input  wire logic d,
    input  wire logic si,
    output logic      q
);
    logic q_d;

    always_comb begin
        if (!observe_point_enable) begin // R7
            q_d = scan_shift_enable ? si : d; // R12
        end else if (scan_shift_enable) begin
            q_d = dyn_en ? (d ^ si) : si; // R5
        end else begin
            q_d = dyn_en ? (d ^ q) : d; // R6
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= 1'b0;
        end else begin
            q <= q_d;
        end
    end
endmodule : osc_cell
`default_nettype wire

// >>> testbench/osc_chk_assertions.sv
// Checker for the observation scan controller's test-side outputs.
// Assumes a chain running from cell 0 to cell NCELL-1, NCELL >= 2.
`timescale 1ns/1ps
`default_nettype none
module osc_chk
    import osc_pkg::*;
#(
    parameter int               NCELL       = 8,
    parameter logic [NCELL-1:0] SHADOW_MASK = '0
)
(
    // Clock and reset
    input wire logic             aclk,
    input wire logic             aresetn,
    // Test side
    input wire logic             scan_shift_enable,
    input wire logic             percycle_static_en,
    input wire logic             percycle_dyn_en,
    input wire logic             sig_accum_en,
    input wire logic             obs_chain_si,
    input wire logic             obs_chain_so,
    input wire logic [NCELL-1:0] obs_node,
    input wire logic [NCELL-1:0] obs_q
);
    localparam int TOP = NCELL - 1;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_shift_plain;
        scan_shift_enable && !percycle_dyn_en;
    endsequence
    sequence s_dyn_rise;
        !percycle_dyn_en ##1 percycle_dyn_en;
    endsequence
    a_dyn_gated: assert property (
        percycle_dyn_en |-> percycle_static_en)
        else $error("dynamic enable without static enable");
    a_dyn_rise_capt: assert property (
        s_dyn_rise |-> !scan_shift_enable)
        else $error("dynamic enable rose during a shift");
    a_shift_si: assert property (
        s_shift_plain |=> obs_q[0] == $past(obs_chain_si))
        else $error("first cell missed serial input");
    a_shift_chain: assert property (
        s_shift_plain |=> obs_q[TOP:1] == $past(obs_q[TOP-1:0]))
        else $error("chain did not shift");
    a_func_load: assert property (
        !scan_shift_enable && !percycle_dyn_en |=> obs_q == $past(obs_node))
        else $error("cells missed functional input");
    a_chain_tail: assert property (
        obs_chain_so == obs_q[TOP])
        else $error("chain output is not the last cell");
    a_shadow_capt: assert property (
        SHADOW_MASK[TOP] && !scan_shift_enable
        |=> obs_q[TOP] == $past(obs_node[TOP]))
        else $error("shadow cone cell folded in capture");
    a_sig_shift: assert property (
        sig_accum_en |-> scan_shift_enable)
        else $error("signature compacts outside shift");
endmodule : osc_chk

bind osc_ctrl osc_chk #(.NCELL(NCELL), .SHADOW_MASK(SHADOW_MASK)) u_chk (
    .aclk, .aresetn, .scan_shift_enable, .percycle_static_en,
    .percycle_dyn_en, .sig_accum_en, .obs_chain_si, .obs_chain_so,
    .obs_node, .obs_q);
`default_nettype wire

// >>> testbench/osc_node_model.sv
// Observed functional logic: nodes and chain input change every cycle.
// Assumes the same clock and reset as the controller.
`timescale 1ns/1ps
`default_nettype none
module osc_node_model
    import osc_pkg::*;
#(
    parameter int NCELL = 8
)
(
    // Clock and reset
    input wire logic         aclk,
    input wire logic         aresetn,
    // Observed logic
    output logic [NCELL-1:0] obs_node     = '0,
    output logic             obs_chain_si = '0
);
    int seed = 77;
    // Fresh random values every cycle so that a stale capture seldom matches
    always @(posedge aclk) begin
        if (!aresetn) begin
            {obs_node, obs_chain_si} <= '0;
        end else begin
            {obs_node, obs_chain_si} <= (NCELL+1)'($random(seed));
        end
    end
endmodule : osc_node_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Bench for the observation scan controller: bus, run schedule, cells.
// Assumes osc_consts.svh on the include path and osc_pkg compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.svh"
module tb_top
    import osc_pkg::*;
;
    localparam int           N  = 8;
    localparam logic [N-1:0] SM = 8'h80;
    logic aclk = '0, aresetn = '0, awv = '0, wv = '0, br = '0, arv = '0;
    logic rr = '0, awy, wy, bv, ary, rv, se, st, dy, sa, so, csi;
    logic [7:0]  awa = '0, ara = '0;
    logic [31:0] wd = '0, rdat, rg;
    logic [1:0]  bresp, rresp, r;
    logic [N-1:0] node, q, pn;
    int n_fail = 0, checks = 0, seed = 77, k;
    logic [7:0]  ra [7] = '{`OSC_OFF_CTRL, `OSC_OFF_WARMUP, `OSC_OFF_BEGIN,
        `OSC_OFF_PATS, `OSC_OFF_SHLEN, `OSC_OFF_STATUS, `OSC_OFF_SIG};
    logic [31:0] rx [7] = '{32'h0, {16'h0, `OSC_RST_WARMUP},
        {16'h0, `OSC_RST_BEGIN}, {16'h0, `OSC_RST_PATS},
        {16'h0, `OSC_RST_SHLEN}, 32'h0, `OSC_RST_SIG};

    initial forever #12.5 aclk = ~aclk;
    // Idle cells load the node, so this is their next value
    always @(posedge aclk) pn = node;

    osc_node_model #(.NCELL(N)) i_obs (.aclk, .aresetn,
        .obs_node(node), .obs_chain_si(csi));
    osc_ctrl #(.NCELL(N), .SHADOW_MASK(SM)) i_dut (.aclk, .aresetn,
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
        .s_axi_awready(awy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(ary),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .obs_node(node), .obs_chain_si(csi),
        .scan_shift_enable(se), .percycle_static_en(st),
        .percycle_dyn_en(dy), .sig_accum_en(sa), .obs_chain_so(so),
        .obs_q(q));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    task automatic tmo(input int n);
        if (n >= 200) begin
            n_fail++;
            $display("[ERR] %0t wait ran out", $time);
            conclude();
        end
    endtask : tmo

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= '1;
        wv <= '1;
        br <= '1;
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (awv && awy) awv <= '0;
            if (wv && wy) wv <= '0;
            if (bv) break;
        end
        tmo(n);
        r = bresp;
        br <= '0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        ara <= a;
        arv <= '1;
        rr <= '1;
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (arv && ary) arv <= '0;
            if (rv) break;
        end
        tmo(n);
        rg = rdat;
        r = rresp;
        rr <= '0;
    endtask : bus_rd

    // One run; the schedule and the cell model are worked out cycle by cycle
    task automatic run(input int w, b, p, l, input logic [2:0] c);
        int f, np, t, cyc, pi, n;
        logic sh, es, ed, eg, dn, sin;
        logic [N-1:0] mq;
        logic [31:0] sig;
        bus_wr(`OSC_OFF_WARMUP, 32'(w));
        bus_wr(`OSC_OFF_BEGIN, 32'(b));
        bus_wr(`OSC_OFF_PATS, 32'(p));
        bus_wr(`OSC_OFF_SHLEN, 32'(l));
        bus_wr(`OSC_OFF_CTRL, {28'h0, 1'h1, c});
        f = (b != 0);
        np = w + f + p;
        t = np * (l + 1) + l;
        for (n = 0; n < 200; n++) begin
            @(negedge aclk);
            if (se) break;
        end
        tmo(n);
        mq = pn;
        sig = 32'h0;
        for (cyc = 0; cyc < t; cyc++) begin
            pi = cyc / (l + 1);
            sh = (pi >= np) || (cyc % (l + 1) < l);
            es = c[0] && !(f && pi == w);
            ed = es && pi >= w + f && !(pi == w + f && sh);
            // Unload counts as pattern np, so it compacts only past the start
            eg = sh && pi >= w + 1 + c[2];
            if (cyc > 0) @(negedge aclk);
            chk(32'(se), 32'(sh));
            chk(32'(st), 32'(es));
            chk(32'(dy), 32'(ed));
            chk(32'(sa), 32'(eg));
            chk(32'(q), 32'(mq));
            chk(32'(so), 32'(mq[N-1]));
            if (eg) sig = {sig[30:0], ^(sig & `OSC_SIG_TAPS)} ^ mq[N-1];
            for (int i = N - 1; i >= 0; i--) begin
                sin = (i > 0) ? mq[i-1] : csi;
                dn = ed && !SM[i];
                if (c[1]) mq[i] = sh ? (dn ? node[i] ^ sin : sin)
                                     : (dn ? node[i] ^ mq[i] : node[i]);
                else mq[i] = sh ? sin : node[i];
            end
        end
        @(negedge aclk);
        chk(32'(se), 32'h0);
        bus_rd(`OSC_OFF_STATUS);
        chk(rg & 32'h3, 32'h2);
        bus_rd(`OSC_OFF_SIG);
        chk(rg, sig);
        $display("run w%0d b%0d p%0d l%0d c%0d done", w, b, p, l, c);
    endtask : run

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= '1;
        bus_wr(`OSC_OFF_STATUS, 32'hffff_ffff);
        bus_wr(`OSC_OFF_SIG, 32'hffff_ffff);
        chk(32'(r), 32'(`OSC_RESP_OKAY));
        for (k = 0; k < 7; k++) begin
            bus_rd(ra[k]);
            chk(rg, rx[k]);
        end
        bus_wr(8'h20, 32'h1);
        chk(32'(r), 32'(`OSC_RESP_SLVERR));
        bus_rd(8'h02);
        chk(32'(r), 32'(`OSC_RESP_SLVERR));
        $display("register test done");
        run(1, 3, 1, 2, 3'h3);
        run(0, 0, 2, 1, 3'h7);
        for (k = 0; k < 8; k++) begin
            run($random(seed) & 3, $random(seed) & 3, 1 + ($random(seed) & 1),
                1 + ($random(seed) & 3), 3'($random(seed)));
        end
        // Zero patterns: start must be refused and done is cleared by it
        bus_wr(`OSC_OFF_PATS, 32'h0);
        bus_wr(`OSC_OFF_BEGIN, 32'h0);
        bus_wr(`OSC_OFF_WARMUP, 32'h0);
        bus_wr(`OSC_OFF_CTRL, 32'h9);
        repeat (20) @(posedge aclk);
        chk(32'(se), 32'h0);
        bus_rd(`OSC_OFF_STATUS);
        chk(rg & 32'h3, 32'h0);
        $display("refusal test done");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
